// [core/lss_pkg.sv]
`default_nettype none
package lss_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [11:0] LNK_OFS      = 12'h078;
    localparam logic [11:0] SLOT_CAP_OFS = 12'h07c;
    // ************************************************************
    // link status and control field positions
    // ************************************************************
    localparam int ASPM_LSB     = 0;
    localparam int LINK_DIS_BIT = 4;
    localparam int RETRAIN_BIT  = 5;
    localparam int COM_CLK_BIT  = 6;
    localparam int EXT_SYNC_BIT = 7;
    localparam int BW_IE_BIT    = 10;
    localparam int ABW_IE_BIT   = 11;
    localparam int SPEED_LSB    = 16;
    localparam int WIDTH_LSB    = 20;
    localparam int TRAIN_BIT    = 27;
    localparam int SLOT_CLK_BIT = 28;
    localparam int DLL_ACT_BIT  = 29;
    localparam int BW_ST_BIT    = 30;
    localparam int ABW_ST_BIT   = 31;
    // ************************************************************
    // slot capability field positions
    // ************************************************************
    localparam int ATTN_BTN_BIT  = 0;
    localparam int PWR_CTL_BIT   = 1;
    localparam int LATCH_SNS_BIT = 2;
    localparam int ATTN_IND_BIT  = 3;
    localparam int HP_CAP_BIT    = 6;
    localparam int INTERLOCK_BIT = 17;
    // ************************************************************
    // codes and reset values
    // ************************************************************
    localparam logic [3:0] SPEED_2G5     = 4'h1;
    localparam logic [3:0] SPEED_5G0     = 4'h2;
    localparam logic [5:0] WIDTH_DOWN    = 6'h00;
    localparam logic [1:0] ASPM_RST      = 2'h0;
    localparam logic [6:0] SLOT_CAP_RST  = 7'h5f;
    localparam logic       INTERLOCK_RST = 1'h1;
    localparam logic       SLOT_CLK_RST  = 1'h0;
endpackage
`default_nettype wire

// [core/lss_link_slot.sv]
// Function
// RULE1: speed field reports negotiated rate code
// RULE2: width field one-hot, zero when down
// RULE3: bit 27 shows requested training pending
// RULE4: bit 28 reports platform reference clock use
// RULE5: bit 29 needs capable, active, FC done
// RULE6: bit 30 set on retrain/reliability, W1C
// RULE7: bit 31 set on autonomous change, W1C
// RULE8: receiver may always enter L0s
// RULE9: capability bits reset one only if hot-plug capable
// RULE10: serial capable only with expander detected
// RULE11: at most one parallel controller per port
// RULE12: ports without parallel controller use serial
// RULE13: serial by default unless override set
// RULE14: bit 0 read-only attention button present
// RULE15: bit 1 clear disables slot power-up
// RULE16: power-up needs latch closed, control clear
// RULE17: latch ignored when sensor bit clear
// RULE18: latch low means closed, power allowed
// RULE19: bit 3 gates active-low attention LED
// RULE20: retrain bit starts training, reads zero
// RULE21: enables gate bandwidth status interrupts
// RULE22: upstream port status and capability read zero
`timescale 1ns/10ps
`default_nettype none
module lss_link_slot #(
    parameter logic DLL_REPORT_CAP = 1'h1
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // register access
    input  wire logic [11:0] reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic        reg_init_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic      [31:0] reg_rdata_o,
    // port configuration
    input  wire logic        port_downstream_i,
    input  wire logic        par_b_owns_i,
    input  wire logic        par_c_owns_i,
    input  wire logic        serial_override_i,
    input  wire logic        expander_present_i,
    input  wire logic        slot_power_off_i,
    input  wire logic        attention_on_i,
    // link state
    input  wire logic        link_up_i,
    input  wire logic [3:0]  link_speed_i,
    input  wire logic [5:0]  link_width_i,
    input  wire logic        dl_active_i,
    input  wire logic        fc_init_done_i,
    input  wire logic        dl_down_i,
    input  wire logic        retrain_done_i,
    input  wire logic        reliab_change_i,
    input  wire logic        auto_change_i,
    // slot
    input  wire logic        retention_latch_i,
    // link control
    output logic             retrain_req_o,
    output logic             link_disable_o,
    output logic      [1:0]  aspm_ctl_o,
    output logic             rx_l0s_allowed_o,
    // hot plug
    output logic             serial_hp_o,
    output logic             parallel_hp_o,
    output logic             par_use_c_o,
    output logic             hp_capable_o,
    output logic             slot_power_up_o,
    output logic             slot_attention_led_n_o,
    // interrupt requests
    output logic             bw_irq_o,
    output logic             abw_irq_o
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [1:0]  aspm;
        logic        link_dis;
        logic        com_clk;
        logic        ext_sync;
        logic        bw_ie;
        logic        abw_ie;
        logic        slot_clk;
        logic        train;
        logic        bw_st;
        logic        abw_st;
        logic        retrain;
        logic [6:0]  cap;
        logic        cap17;
        logic [31:0] rdata;
    } lss_state_type;

    lss_state_type st_q;
    lss_state_type st_d;

    logic        dn;
    logic        wr_lnk;
    logic        wr_cap;
    logic        rd_lnk;
    logic        rd_cap;
    logic [6:0]  cap_eff;
    logic        cap17_eff;
    logic [31:0] lnk_word;
    logic [31:0] cap_word;

    assign dn     = port_downstream_i;
    assign wr_lnk = reg_wr_i && (reg_addr_i == lss_pkg::LNK_OFS);
    assign wr_cap = reg_wr_i && (reg_addr_i == lss_pkg::SLOT_CAP_OFS);
    assign rd_lnk = reg_rd_i && (reg_addr_i == lss_pkg::LNK_OFS);
    assign rd_cap = reg_rd_i && (reg_addr_i == lss_pkg::SLOT_CAP_OFS);

    // ************************************************************
    // hot plug controller selection
    // ************************************************************
    // parallel only when assigned and the serial default is overridden
    assign parallel_hp_o = dn && (par_b_owns_i || par_c_owns_i) && serial_override_i; // [RULE11] [RULE13]
    // controller b wins if software assigns both, so one port owns one
    assign par_use_c_o   = parallel_hp_o && !par_b_owns_i;                           // [RULE11]
    assign serial_hp_o   = dn && !parallel_hp_o;                                     // [RULE12] [RULE13]
    assign hp_capable_o  = parallel_hp_o || (serial_hp_o && expander_present_i);     // [RULE10]

    // stored bits keep their loaded value; capability gates what is seen
    assign cap_eff   = (dn && hp_capable_o) ? st_q.cap : 7'h00;                      // [RULE9] [RULE22]
    assign cap17_eff = dn && serial_hp_o && hp_capable_o && st_q.cap17;              // [RULE9]

    // ************************************************************
    // slot power and indicators
    // ************************************************************
    // latch input low means closed
    assign slot_power_up_o = cap_eff[lss_pkg::PWR_CTL_BIT] && !slot_power_off_i &&   // [RULE15] [RULE16]
                             (!cap_eff[lss_pkg::LATCH_SNS_BIT] || !retention_latch_i); // [RULE17] [RULE18]
    // led idles high when the indicator is absent
    assign slot_attention_led_n_o = !(cap_eff[lss_pkg::ATTN_IND_BIT] && attention_on_i); // [RULE19]

    // ************************************************************
    // link control outputs
    // ************************************************************
    assign retrain_req_o    = st_q.retrain;                                          // [RULE20]
    assign link_disable_o   = st_q.link_dis;
    assign aspm_ctl_o       = st_q.aspm;
    // the receiver side of L0s never depends on the aspm enables
    assign rx_l0s_allowed_o = 1'h1;                                                  // [RULE8]
    assign bw_irq_o         = dn && st_q.bw_ie && st_q.bw_st;                        // [RULE21]
    assign abw_irq_o        = dn && st_q.abw_ie && st_q.abw_st;                      // [RULE21]
    assign reg_rdata_o      = st_q.rdata;

    // ************************************************************
    // read words
    // ************************************************************
    always_comb begin
        lnk_word = 32'h0000_0000;
        lnk_word[lss_pkg::ASPM_LSB +: 2]     = st_q.aspm;
        lnk_word[lss_pkg::LINK_DIS_BIT]      = dn && st_q.link_dis;
        lnk_word[lss_pkg::COM_CLK_BIT]       = st_q.com_clk;
        lnk_word[lss_pkg::EXT_SYNC_BIT]      = st_q.ext_sync;
        lnk_word[lss_pkg::BW_IE_BIT]         = dn && st_q.bw_ie;
        lnk_word[lss_pkg::ABW_IE_BIT]        = dn && st_q.abw_ie;
        // speed is undefined while down; the live code is passed anyway
        lnk_word[lss_pkg::SPEED_LSB +: 4]    = link_speed_i;                         // [RULE1]
        lnk_word[lss_pkg::WIDTH_LSB +: 6]    = link_up_i ? link_width_i : lss_pkg::WIDTH_DOWN; // [RULE2]
        lnk_word[lss_pkg::TRAIN_BIT]         = dn && st_q.train;                     // [RULE3]
        lnk_word[lss_pkg::SLOT_CLK_BIT]      = st_q.slot_clk;                        // [RULE4]
        lnk_word[lss_pkg::DLL_ACT_BIT]       = dn && DLL_REPORT_CAP && dl_active_i &&
                                               link_up_i && fc_init_done_i;          // [RULE5]
        lnk_word[lss_pkg::BW_ST_BIT]         = dn && st_q.bw_st;                     // [RULE22]
        lnk_word[lss_pkg::ABW_ST_BIT]        = dn && st_q.abw_st;                    // [RULE22]
        cap_word = 32'h0000_0000;
        cap_word[6:0]                        = cap_eff;                              // [RULE14]
        cap_word[lss_pkg::INTERLOCK_BIT]     = cap17_eff;
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_d = st_q;
        st_d.retrain = 1'h0;
        if (wr_lnk) begin
            st_d.aspm     = reg_wdata_i[lss_pkg::ASPM_LSB +: 2];
            st_d.com_clk  = reg_wdata_i[lss_pkg::COM_CLK_BIT];
            st_d.ext_sync = reg_wdata_i[lss_pkg::EXT_SYNC_BIT];
            if (dn) begin
                st_d.link_dis = reg_wdata_i[lss_pkg::LINK_DIS_BIT];
                st_d.bw_ie    = reg_wdata_i[lss_pkg::BW_IE_BIT];
                st_d.abw_ie   = reg_wdata_i[lss_pkg::ABW_IE_BIT];
                st_d.retrain  = reg_wdata_i[lss_pkg::RETRAIN_BIT];                   // [RULE20]
            end
            if (reg_init_i) begin
                st_d.slot_clk = reg_wdata_i[lss_pkg::SLOT_CLK_BIT];                  // [RULE4]
            end
            // write-one-to-clear; a set in the same cycle wins below
            if (reg_wdata_i[lss_pkg::BW_ST_BIT]) begin
                st_d.bw_st = 1'h0;
            end
            if (reg_wdata_i[lss_pkg::ABW_ST_BIT]) begin
                st_d.abw_st = 1'h0;
            end
        end
        // capability bits are only loaded by initialisation accesses
        if (wr_cap && reg_init_i) begin
            st_d.cap   = reg_wdata_i[6:0];
            st_d.cap17 = reg_wdata_i[lss_pkg::INTERLOCK_BIT];
        end
        // training pending from the request until completion or link loss
        if (!dn || dl_down_i) begin
            st_d.train = 1'h0;
        end else if (st_d.retrain) begin
            st_d.train = 1'h1;                                                       // [RULE3]
        end else if (retrain_done_i) begin
            st_d.train = 1'h0;
        end
        if (dn && !dl_down_i && ((st_q.train && retrain_done_i) || reliab_change_i)) begin
            st_d.bw_st = 1'h1;                                                       // [RULE6]
        end
        if (dn && !dl_down_i && auto_change_i) begin
            st_d.abw_st = 1'h1;                                                      // [RULE7]
        end
        if (!dn) begin
            st_d.bw_st  = 1'h0;                                                      // [RULE22]
            st_d.abw_st = 1'h0;
        end
        if (rd_lnk) begin
            st_d.rdata = lnk_word;
        end else if (rd_cap) begin
            st_d.rdata = cap_word;
        end else if (reg_rd_i) begin
            st_d.rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_q          <= '0;
            st_q.aspm     <= lss_pkg::ASPM_RST;
            st_q.slot_clk <= lss_pkg::SLOT_CLK_RST;
            st_q.cap      <= lss_pkg::SLOT_CAP_RST;                                  // [RULE9]
            st_q.cap17    <= lss_pkg::INTERLOCK_RST;
        end else if (ce_i) begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    chk_speed_report: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE1]
        (ce_i && rd_lnk) |=> reg_rdata_o[19:16] == $past(link_speed_i))
        else $error("speed field does not match link");
    chk_width_down: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE2]
        (ce_i && rd_lnk && !link_up_i) |=> reg_rdata_o[25:20] == 6'h00)
        else $error("width not zero while link down");
    chk_train_pend: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE3]
        (ce_i && wr_lnk && dn && reg_wdata_i[5] && !dl_down_i) |=> st_q.train ##1
            (st_q.train || $past(!dn || dl_down_i || retrain_done_i)))
        else $error("training flag not raised by retrain");
    chk_dll_active: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE5]
        (ce_i && rd_lnk) |=> reg_rdata_o[29] ==
            $past(dn && dl_active_i && link_up_i && fc_init_done_i && DLL_REPORT_CAP))
        else $error("link active bit wrong");
    chk_bw_set: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE6]
        (ce_i && dn && !dl_down_i && reliab_change_i) |=> st_q.bw_st)
        else $error("bandwidth status not set");
    chk_bw_retrain: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE6]
        (ce_i && dn && !dl_down_i && st_q.train && retrain_done_i) |=> st_q.bw_st)
        else $error("bandwidth status not set after retrain");
    chk_serial_capable: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE10]
        serial_hp_o && !expander_present_i |-> !hp_capable_o && cap_eff == 7'h00)
        else $error("serial port capable without expander");
    chk_abw_set: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE7]
        (ce_i && dn && !dl_down_i && auto_change_i) |=> st_q.abw_st)
        else $error("autonomous status not set");
    chk_l0s_rx: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE8]
        aspm_ctl_o == 2'h0 |-> rx_l0s_allowed_o)
        else $error("receiver L0s blocked");
    chk_no_power: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE15]
        !cap_eff[1] || slot_power_off_i |-> !slot_power_up_o)
        else $error("slot powered without controller");
    chk_latch_open: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE18]
        cap_eff[2] && retention_latch_i |-> !slot_power_up_o)
        else $error("slot powered with latch open");
    chk_led_off: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE19]
        !cap_eff[3] |-> slot_attention_led_n_o)
        else $error("attention led driven without indicator");
    chk_retrain_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE20]
        (ce_i && rd_lnk) |=> !reg_rdata_o[5])
        else $error("retrain bit read back as one");
    chk_upstream_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE22]
        !dn |-> cap_eff == 7'h00 && !bw_irq_o && !abw_irq_o)
        else $error("upstream port shows downstream state");
    chk_serial_default: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [RULE13]
        dn && !serial_override_i |-> serial_hp_o && !parallel_hp_o)
        else $error("serial default not applied");
    cov_retrain_done: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        st_q.train ##[1:20] st_q.bw_st);
    cov_power_up: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        cap_eff[2] && slot_power_up_o);
    cov_abw_irq: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        abw_irq_o ##1 !st_q.abw_st);
    cov_parallel_c: cover property (@(posedge ref_clk_i) disable iff (rst_i)
        par_use_c_o && hp_capable_o);
endmodule // lss_link_slot
`default_nettype wire

// [bench/lss_link_partner.sv]
`timescale 1ns/10ps
`default_nettype none
module lss_link_partner (
    // clock and bench controls
    input  wire logic       ref_clk_i,
    input  wire logic       retrain_req_i,
    input  wire logic       up_i,
    input  wire logic       latch_closed_i,
    // link and slot state towards the port
    output logic            link_up_o,
    output logic      [3:0] speed_o,
    output logic      [5:0] width_o,
    output logic            dl_active_o,
    output logic            fc_done_o,
    output logic            retrain_done_o,
    output logic            latch_o
);
    // ************************************************************
    // link and slot behaviour
    // ************************************************************
    logic [2:0] wait_q = 3'h0;
    logic       done_q = 1'h0;
    // codes toggle every cycle while down, so nothing may rely on them
    logic [9:0] junk_q = 10'h155;
    assign link_up_o      = up_i;
    assign speed_o        = up_i ? lss_pkg::SPEED_5G0 : junk_q[3:0];
    assign width_o        = up_i ? 6'h04 : junk_q[9:4];
    assign dl_active_o    = up_i;
    assign fc_done_o      = up_i;
    assign retrain_done_o = done_q;
    assign latch_o        = ~latch_closed_i;
    // retraining takes a few cycles before the link reports it done
    always @(posedge ref_clk_i) begin
        junk_q <= ~junk_q;
        done_q <= (wait_q == 3'h1);
        if (retrain_req_i) begin
            wait_q <= 3'h4;
        end else if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
        end
    end
endmodule // lss_link_partner
`default_nettype wire

// [bench/link_status_slot_capability_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module link_status_slot_capability_bench;
    // ************************************************************
    // stimulus and wiring
    // ************************************************************
    logic        ref_clk_i = 1'h0, rst_i = 1'h1, up = 1'h0, latch_closed = 1'h1, ce_i = 1'h1;
    logic        reg_wr_i = 1'h0, reg_rd_i = 1'h0, reg_init_i = 1'h0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
    logic        port_downstream_i = 1'h1, par_b_owns_i = 1'h0, par_c_owns_i = 1'h0;
    logic        serial_override_i = 1'h0, expander_present_i = 1'h1;
    logic        slot_power_off_i = 1'h0, attention_on_i = 1'h0;
    logic        dl_down_i = 1'h0, reliab_change_i = 1'h0, auto_change_i = 1'h0;
    logic        link_up_i, dl_active_i, fc_init_done_i, retrain_done_i, retention_latch_i;
    logic [3:0]  link_speed_i;
    logic [5:0]  link_width_i;
    logic [1:0]  aspm_ctl_o;
    logic        retrain_req_o, link_disable_o, rx_l0s_allowed_o, serial_hp_o, parallel_hp_o;
    logic        par_use_c_o, hp_capable_o, slot_power_up_o, slot_attention_led_n_o, bw_irq_o, abw_irq_o;
    int          num_errors = 0, check_count = 0;

    always #2.5 ref_clk_i = ~ref_clk_i;

    lss_link_slot u_dut (
        .ref_clk_i, .rst_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_init_i,
        .reg_wdata_i, .reg_rdata_o, .port_downstream_i, .par_b_owns_i, .par_c_owns_i,
        .serial_override_i, .expander_present_i, .slot_power_off_i, .attention_on_i,
        .link_up_i, .link_speed_i, .link_width_i, .dl_active_i, .fc_init_done_i, .dl_down_i,
        .retrain_done_i, .reliab_change_i, .auto_change_i, .retention_latch_i, .retrain_req_o,
        .link_disable_o, .aspm_ctl_o, .rx_l0s_allowed_o, .serial_hp_o, .parallel_hp_o,
        .par_use_c_o, .hp_capable_o, .slot_power_up_o, .slot_attention_led_n_o, .bw_irq_o, .abw_irq_o
    );

    lss_link_partner u_partner (
        .ref_clk_i, .retrain_req_i(retrain_req_o), .up_i(up), .latch_closed_i(latch_closed),
        .link_up_o(link_up_i), .speed_o(link_speed_i), .width_o(link_width_i),
        .dl_active_o(dl_active_i), .fc_done_o(fc_init_done_i), .retrain_done_o(retrain_done_i),
        .latch_o(retention_latch_i)
    );

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string msg);
        chk({31'h0, got}, {31'h0, exp}, msg);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic init);
        @(posedge ref_clk_i);
        reg_wr_i    <= 1'h1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_init_i  <= init;
        @(posedge ref_clk_i);
        reg_wr_i   <= 1'h0;
        reg_init_i <= 1'h0;
        #1;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp, input string msg);
        @(posedge ref_clk_i);
        reg_rd_i   <= 1'h1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'h0;
        @(posedge ref_clk_i);
        #1;
        chk(reg_rdata_o & m, exp, msg);
    endtask

    task automatic ev(input logic au, input logic rl, input logic dn);
        @(posedge ref_clk_i);
        auto_change_i   <= au;
        reliab_change_i <= rl;
        dl_down_i       <= dn;
        @(posedge ref_clk_i);
        auto_change_i   <= 1'h0;
        reliab_change_i <= 1'h0;
        dl_down_i       <= 1'h0;
        @(posedge ref_clk_i);
        #1;
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        rd(12'h078, 32'hfff0_ffff, 32'h0, "link reg reset");
        rd(12'h07c, 32'hffff_ffff, 32'h0002_005f, "slot cap reset");
        rd(12'h100, 32'hffff_ffff, 32'h0, "unmapped read");
        chk1(rx_l0s_allowed_o, 1'h1, "l0s blocked");
    endtask

    task automatic t_retrain();
        @(posedge ref_clk_i);
        up <= 1'h1;
        rd(12'h078, 32'hffff_ffff, 32'h2042_0000, "link up fields");
        wr(12'h078, 32'h0000_0420, 1'h0);
        chk1(retrain_req_o, 1'h1, "no retrain pulse");
        rd(12'h078, 32'hffff_ffff, 32'h2842_0400, "training flag");
        repeat (6) @(posedge ref_clk_i);
        rd(12'h078, 32'hffff_ffff, 32'h6042_0400, "bw status not set");
        chk1(bw_irq_o, 1'h1, "bw irq missing");
        wr(12'h078, 32'h4000_0400, 1'h0);
        rd(12'h078, 32'hffff_ffff, 32'h2042_0400, "bw status not cleared");
        chk1(bw_irq_o, 1'h0, "bw irq stuck");
    endtask

    task automatic t_events();
        wr(12'h078, 32'h0000_0c00, 1'h0);
        // events while the clock enable is low must leave all state frozen
        @(posedge ref_clk_i);
        ce_i <= 1'h0;
        ev(1'h1, 1'h1, 1'h0);
        @(posedge ref_clk_i);
        ce_i <= 1'h1;
        rd(12'h078, 32'hffff_ffff, 32'h2042_0c00, "state moved while frozen");
        ev(1'h1, 1'h0, 1'h0);
        rd(12'h078, 32'hffff_ffff, 32'ha042_0c00, "auto status not set");
        chk1(abw_irq_o, 1'h1, "abw irq missing");
        wr(12'h078, 32'h8000_0c00, 1'h0);
        ev(1'h1, 1'h1, 1'h1);
        rd(12'h078, 32'hffff_ffff, 32'h2042_0c00, "set through link down");
        ev(1'h0, 1'h1, 1'h0);
        rd(12'h078, 32'hffff_ffff, 32'h6042_0c00, "reliability change lost");
        wr(12'h078, 32'h4000_0013, 1'h0);
        chk({29'h0, link_disable_o, aspm_ctl_o}, 32'h0000_0007, "link control outputs");
    endtask

    task automatic t_slot();
        wr(12'h078, 32'h1000_0000, 1'h0);
        rd(12'h078, 32'h1000_0000, 32'h0, "clock bit writable");
        wr(12'h078, 32'h1000_0000, 1'h1);
        rd(12'h078, 32'h1000_0000, 32'h1000_0000, "clock bit not loaded");
        chk1(slot_power_up_o, 1'h1, "slot not powered");
        @(posedge ref_clk_i);
        latch_closed   <= 1'h0;
        attention_on_i <= 1'h1;
        @(posedge ref_clk_i);
        #1;
        chk1(slot_power_up_o, 1'h0, "powered with latch open");
        chk1(slot_attention_led_n_o, 1'h0, "attention led off");
        wr(12'h07c, 32'h0, 1'h0);
        rd(12'h07c, 32'hffff_ffff, 32'h0002_005f, "cap writable");
        wr(12'h07c, 32'h0002_005b, 1'h1);
        chk1(slot_power_up_o, 1'h1, "latch not ignored");
        wr(12'h07c, 32'h0002_0059, 1'h1);
        chk1(slot_power_up_o, 1'h0, "power without controller");
        wr(12'h07c, 32'h0002_0057, 1'h1);
        chk1(slot_attention_led_n_o, 1'h1, "led without indicator");
        rd(12'h07c, 32'hffff_ffff, 32'h0002_0057, "cap load");
        wr(12'h07c, 32'h0002_005f, 1'h1);
        @(posedge ref_clk_i);
        latch_closed     <= 1'h1;
        slot_power_off_i <= 1'h1;
        @(posedge ref_clk_i);
        #1;
        chk1(slot_power_up_o, 1'h0, "powered with control set");
    endtask

    task automatic t_select();
        logic par;
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk_i);
            expander_present_i <= i[0];
            serial_override_i  <= i[1];
            par_b_owns_i       <= i[2];
            par_c_owns_i       <= i[3];
            @(posedge ref_clk_i);
            #1;
            par = i[1] & (i[2] | i[3]);
            chk({29'h0, parallel_hp_o, par_use_c_o, serial_hp_o},
                {29'h0, par, par & i[3] & ~i[2], ~par}, "controller choice");
            chk1(hp_capable_o, par | i[0], "capability");
        end
        rd(12'h07c, 32'hffff_ffff, 32'h0000_005f, "interlock on parallel port");
        @(posedge ref_clk_i);
        expander_present_i <= 1'h0;
        serial_override_i  <= 1'h0;
        rd(12'h07c, 32'hffff_ffff, 32'h0, "cap without expander");
    endtask

    task automatic t_upstream();
        @(posedge ref_clk_i);
        port_downstream_i <= 1'h0;
        wr(12'h078, 32'h0000_0c30, 1'h0);
        chk1(retrain_req_o, 1'h0, "upstream retrain");
        chk1(link_disable_o, 1'h0, "upstream link disable");
        ev(1'h1, 1'h1, 1'h0);
        rd(12'h078, 32'he800_0c30, 32'h0, "upstream status");
        rd(12'h07c, 32'hffff_ffff, 32'h0, "upstream cap");
    endtask

    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'h0;
        t_reset();
        t_retrain();
        t_events();
        t_slot();
        t_select();
        t_upstream();
        print_verdict();
    end

    // about 150 cycles are needed, so this leaves ample room
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end
endmodule // link_status_slot_capability_bench
`default_nettype wire
